// ===== hw/rcr_pkg.sv
package rcr_pkg;
   // ==========================================
   // program counter values
   localparam int PC_W = 15;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [14:0] PC_IRQ_VEC = 15'h0004;
   // ==========================================
   // status cause field bit positions (5 bits, msb first)
   localparam int ST_EXP = 4;
   localparam int ST_PDN = 3;
   localparam logic [4:0] STATUS_POR = 5'h18;
   // ==========================================
   // power control bit positions (8 bits, bit 5 unimplemented)
   localparam int PC_OVF = 7;
   localparam int PC_UNF = 6;
   localparam int PC_WDT = 4;
   localparam int PC_PIN = 3;
   localparam int PC_SOFT = 2;
   localparam int PC_POR = 1;
   localparam int PC_BOR = 0;
   localparam logic [7:0] POWER_CONTROL_REG_POR = 8'h1C;
   localparam logic [7:0] POWER_CONTROL_REG_MASK = 8'hDF;
   // ==========================================
   // event codes, not in the priority order that rcr_event_sel applies
   typedef enum logic [3:0] {
      RCR_EV_NONE, RCR_EV_POR, RCR_EV_BOR, RCR_EV_PIN_RUN, RCR_EV_PIN_SLP, RCR_EV_WDT_RST,
      RCR_EV_OVF, RCR_EV_UNF, RCR_EV_SOFT, RCR_EV_WDT_WAKE, RCR_EV_IRQ_WAKE
   } rcr_ev_t;
endpackage

// ===== hw/rcr_event_sel.sv
`timescale 1ns/10ps
module rcr_event_sel (
   input wire logic por_i,          // power-on
   input wire logic bor_i,          // brown-out
   input wire logic pin_i,          // master clear pin
   input wire logic asleep_i,       // core sleeping
   input wire logic wdt_i,          // watchdog timeout
   input wire logic soft_i,         // reset instruction
   input wire logic ovf_i,          // stack overflow
   input wire logic unf_i,          // stack underflow
   input wire logic stk_en_i,       // stack fault reset enable
   input wire logic irq_i,          // interrupt wake
   output rcr_pkg::rcr_ev_t ev_o    // chosen event
);
   always_comb begin
      ev_o = rcr_pkg::RCR_EV_NONE;
      if (por_i) ev_o = rcr_pkg::RCR_EV_POR;
      else if (bor_i) ev_o = rcr_pkg::RCR_EV_BOR;
      else if (pin_i && asleep_i) ev_o = rcr_pkg::RCR_EV_PIN_SLP;
      else if (pin_i) ev_o = rcr_pkg::RCR_EV_PIN_RUN;
      else if (wdt_i && asleep_i) ev_o = rcr_pkg::RCR_EV_WDT_WAKE;
      else if (wdt_i) ev_o = rcr_pkg::RCR_EV_WDT_RST;
      else if (ovf_i && stk_en_i) ev_o = rcr_pkg::RCR_EV_OVF;
      else if (unf_i && stk_en_i) ev_o = rcr_pkg::RCR_EV_UNF;
      else if (soft_i && !asleep_i) ev_o = rcr_pkg::RCR_EV_SOFT;
      else if (irq_i && asleep_i) ev_o = rcr_pkg::RCR_EV_IRQ_WAKE;
   end
endmodule

// ===== hw/rcr_recorder.sv
`timescale 1ns/10ps
// Functional notes
// R01 - every reset event updates cause bits in status or power control
// R02 - power-on clears por and stack flags, sets others, brown-out undefined
// R03 - power-on always sets watchdog expired and powerdown flags
// R04 - brown-out clears bor and stack flags, sets pin/soft/expired/powerdown
// R05 - watchdog reset clears wdt and expired flags, pc restarts at zero
// R06 - watchdog wake clears expired and powerdown, pc advances by one
// R07 - interrupt wake sets expired, clears powerdown, pc advances by one
// R08 - interrupt wake with irqs enabled runs next instruction, pushes, jumps to vector
// R09 - pin reset running clears pin flag only, pc zero
// R10 - pin reset asleep clears pin flag, sets expired, clears powerdown
// R11 - reset instruction clears soft flag only, pc zero
// R12 - enabled stack overflow resets, sets overflow flag, pc zero
// R13 - enabled stack underflow resets, sets underflow flag, pc zero
// R14 - power-on loads pc zero, status 1 1000, power control 00-1 110x
// R15 - cause flags otherwise hold until software writes them
module rcr_recorder (
   input wire logic core_clk_i,           // core clock 200 MHz
   input wire logic rst_n_i,              // sync reset, active low
   input wire logic por_i,                // power-on event pulse
   input wire logic bor_i,                // brown-out event pulse
   input wire logic pin_i,                // master clear pin event pulse
   input wire logic asleep_i,             // core in sleep
   input wire logic wdt_i,                // watchdog timeout pulse
   input wire logic soft_i,               // reset instruction pulse
   input wire logic ovf_i,                // stack overflow pulse
   input wire logic unf_i,                // stack underflow pulse
   input wire logic stk_en_i,             // stack_fault_reset_enable
   input wire logic irq_i,                // interrupt wake pulse
   input wire logic gie_i,                // global_irq_enable
   input wire logic [14:0] pc_i,          // current program_counter
   input wire logic sw_wr_i,              // software write of power control
   input wire logic [7:0] sw_data_i,      // written value
   output logic [4:0] status_o,           // status cause field
   output logic [7:0] power_control_reg_o,             // power_control_reg
   output logic [14:0] pc_o,              // program_counter to load
   output logic pc_load_o,                // load pc pulse
   output logic push_o,                   // push return address pulse
   output logic core_rst_o                // core reset pulse
);
   // ==========================================
   // event select
   rcr_pkg::rcr_ev_t ev;
   rcr_event_sel u_sel (
      .por_i(por_i), .bor_i(bor_i), .pin_i(pin_i), .asleep_i(asleep_i), .wdt_i(wdt_i),
      .soft_i(soft_i), .ovf_i(ovf_i), .unf_i(unf_i), .stk_en_i(stk_en_i), .irq_i(irq_i),
      .ev_o(ev)
   );
   // ==========================================
   // recorder state
   logic [4:0] status_r, status_nxt;
   logic [7:0] power_control_reg_r, power_control_reg_nxt;
   logic [14:0] pc_r, pc_nxt;
   logic pc_load_r, pc_load_nxt, push_r, push_nxt, rst_r, rst_nxt, vec_r, vec_nxt;
   always_comb begin
      status_nxt = status_r;
      power_control_reg_nxt = power_control_reg_r;
      pc_nxt = pc_r;
      pc_load_nxt = 1'b0;
      push_nxt = 1'b0;
      rst_nxt = 1'b0;
      vec_nxt = 1'b0;
      if (sw_wr_i) power_control_reg_nxt = sw_data_i & rcr_pkg::POWER_CONTROL_REG_MASK; // [R15]
      if (vec_r) begin // [R08]
         pc_nxt = rcr_pkg::PC_IRQ_VEC;
         pc_load_nxt = 1'b1;
         push_nxt = 1'b1;
      end
      unique case (ev) // [R01]
         rcr_pkg::RCR_EV_NONE: ;
         rcr_pkg::RCR_EV_POR: begin
            status_nxt = rcr_pkg::STATUS_POR; // [R02] [R03] [R14]
            power_control_reg_nxt = rcr_pkg::POWER_CONTROL_REG_POR; // [R02] [R14]
         end
         rcr_pkg::RCR_EV_BOR: begin
            status_nxt[rcr_pkg::ST_EXP] = 1'b1; // [R04]
            status_nxt[rcr_pkg::ST_PDN] = 1'b1;
            power_control_reg_nxt[rcr_pkg::PC_OVF] = 1'b0;
            power_control_reg_nxt[rcr_pkg::PC_UNF] = 1'b0;
            power_control_reg_nxt[rcr_pkg::PC_PIN] = 1'b1;
            power_control_reg_nxt[rcr_pkg::PC_SOFT] = 1'b1;
            power_control_reg_nxt[rcr_pkg::PC_BOR] = 1'b0;
         end
         rcr_pkg::RCR_EV_PIN_RUN: power_control_reg_nxt[rcr_pkg::PC_PIN] = 1'b0; // [R09]
         rcr_pkg::RCR_EV_PIN_SLP: begin
            power_control_reg_nxt[rcr_pkg::PC_PIN] = 1'b0; // [R10]
            status_nxt[rcr_pkg::ST_EXP] = 1'b1;
            status_nxt[rcr_pkg::ST_PDN] = 1'b0;
         end
         rcr_pkg::RCR_EV_WDT_RST: begin
            power_control_reg_nxt[rcr_pkg::PC_WDT] = 1'b0; // [R05]
            status_nxt[rcr_pkg::ST_EXP] = 1'b0;
         end
         rcr_pkg::RCR_EV_OVF: power_control_reg_nxt[rcr_pkg::PC_OVF] = 1'b1; // [R12]
         rcr_pkg::RCR_EV_UNF: power_control_reg_nxt[rcr_pkg::PC_UNF] = 1'b1; // [R13]
         rcr_pkg::RCR_EV_SOFT: power_control_reg_nxt[rcr_pkg::PC_SOFT] = 1'b0; // [R11]
         rcr_pkg::RCR_EV_WDT_WAKE: begin
            status_nxt[rcr_pkg::ST_EXP] = 1'b0; // [R06]
            status_nxt[rcr_pkg::ST_PDN] = 1'b0;
         end
         rcr_pkg::RCR_EV_IRQ_WAKE: begin
            status_nxt[rcr_pkg::ST_EXP] = 1'b1; // [R07]
            status_nxt[rcr_pkg::ST_PDN] = 1'b0;
            vec_nxt = gie_i; // [R08]
         end
         default: ;
      endcase
      if (ev == rcr_pkg::RCR_EV_WDT_WAKE || ev == rcr_pkg::RCR_EV_IRQ_WAKE) begin
         pc_nxt = 15'(pc_i + 15'h0001); // [R06] [R07]
         pc_load_nxt = 1'b1;
         push_nxt = 1'b0;
      end else if (ev != rcr_pkg::RCR_EV_NONE) begin
         pc_nxt = rcr_pkg::PC_RESET; // [R05] [R09] [R11] [R12] [R13] [R14]
         pc_load_nxt = 1'b1;
         push_nxt = 1'b0;
         rst_nxt = 1'b1;
         vec_nxt = 1'b0;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         status_r <= rcr_pkg::STATUS_POR;
         power_control_reg_r <= rcr_pkg::POWER_CONTROL_REG_POR;
         pc_r <= rcr_pkg::PC_RESET;
         pc_load_r <= 1'b0;
         push_r <= 1'b0;
         rst_r <= 1'b0;
         vec_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         power_control_reg_r <= power_control_reg_nxt;
         pc_r <= pc_nxt;
         pc_load_r <= pc_load_nxt;
         push_r <= push_nxt;
         rst_r <= rst_nxt;
         vec_r <= vec_nxt;
      end
   end
   assign status_o = status_r;
   assign power_control_reg_o = power_control_reg_r;
   assign pc_o = pc_r;
   assign pc_load_o = pc_load_r;
   assign push_o = push_r;
   assign core_rst_o = rst_r;
   // ==========================================
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_por_flags: assert property (por_i |=> status_o == 5'h18 && power_control_reg_o == 8'h1C) // [R02]
      else $error("power-on flags wrong");
   chk_por_exp_pd: assert property (por_i |=> status_o[4] && status_o[3]) // [R03]
      else $error("power-on expired or powerdown clear");
   chk_por_pc: assert property (por_i |=> pc_load_o && pc_o == 15'h0000 && core_rst_o) // [R14]
      else $error("power-on pc wrong");
   chk_bor_flags: assert property (!por_i && bor_i |=> power_control_reg_o[7:6] == 2'b00 && !power_control_reg_o[0]
      && power_control_reg_o[3] && power_control_reg_o[2] && status_o[4:3] == 2'b11) // [R04]
      else $error("brown-out flags wrong");
   chk_wdt_reset: assert property (ev == rcr_pkg::RCR_EV_WDT_RST |=> !power_control_reg_o[4] && !status_o[4]
      && pc_o == 15'h0000) // [R05]
      else $error("watchdog reset wrong");
   chk_wdt_wake: assert property (ev == rcr_pkg::RCR_EV_WDT_WAKE |=> status_o[4:3] == 2'b00
      && pc_o == 15'($past(pc_i) + 15'h0001) && !core_rst_o) // [R06]
      else $error("watchdog wake wrong");
   chk_irq_wake: assert property (ev == rcr_pkg::RCR_EV_IRQ_WAKE |=> status_o[4:3] == 2'b10
      && !core_rst_o) // [R07]
      else $error("interrupt wake wrong");
   chk_irq_vector: assert property (ev == rcr_pkg::RCR_EV_IRQ_WAKE && gie_i
      ##1 ev == rcr_pkg::RCR_EV_NONE |=> push_o && pc_o == 15'h0004) // [R08]
      else $error("vector not taken");
   chk_pin_run: assert property (ev == rcr_pkg::RCR_EV_PIN_RUN |=> !power_control_reg_o[3]
      && power_control_reg_o[7:4] == $past(power_control_reg_o[7:4]) && status_o == $past(status_o)) // [R09]
      else $error("pin reset wrong");
   chk_pin_sleep: assert property (ev == rcr_pkg::RCR_EV_PIN_SLP |=> !power_control_reg_o[3]
      && status_o[4:3] == 2'b10) // [R10]
      else $error("pin sleep reset wrong");
   chk_soft_reset: assert property (ev == rcr_pkg::RCR_EV_SOFT |=> !power_control_reg_o[2]
      && status_o == $past(status_o) && core_rst_o) // [R11]
      else $error("soft reset wrong");
   chk_stack_ovf: assert property (ev == rcr_pkg::RCR_EV_OVF |=> power_control_reg_o[7] && core_rst_o) // [R12]
      else $error("overflow reset wrong");
   chk_stack_unf: assert property (ev == rcr_pkg::RCR_EV_UNF |=> power_control_reg_o[6] && core_rst_o) // [R13]
      else $error("underflow reset wrong");
   chk_hold_flags: assert property (ev == rcr_pkg::RCR_EV_NONE && !sw_wr_i
      |=> power_control_reg_o == $past(power_control_reg_o) && status_o == $past(status_o)) // [R15]
      else $error("flags changed without cause");
   chk_any_event: assert property (ev != rcr_pkg::RCR_EV_NONE |=> pc_load_o) // [R01]
      else $error("no update on event");
   cov_por: cover property (por_i ##1 pc_load_o);
   cov_irq_vec: cover property (ev == rcr_pkg::RCR_EV_IRQ_WAKE && gie_i ##2 push_o);
   cov_wdt_wake: cover property (ev == rcr_pkg::RCR_EV_WDT_WAKE);
   cov_ovf: cover property (ev == rcr_pkg::RCR_EV_OVF);
endmodule

// ===== sim/reset_cause_recorder_bench.sv
`timescale 1ns/10ps
module reset_cause_recorder_bench;
   // ==========================================
   // event bit positions in the stimulus vector
   localparam logic [7:0] E_POR = 8'h01;
   localparam logic [7:0] E_BOR = 8'h02;
   localparam logic [7:0] E_PIN = 8'h04;
   localparam logic [7:0] E_WDT = 8'h08;
   localparam logic [7:0] E_SOFT = 8'h10;
   localparam logic [7:0] E_OVF = 8'h20;
   localparam logic [7:0] E_UNF = 8'h40;
   localparam logic [7:0] E_IRQ = 8'h80;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] ev = 8'h00;
   logic asleep = 1'b0;
   logic stk_en = 1'b0;
   logic global_irq_enable = 1'b0;
   logic [14:0] pc_in = 15'h0000;
   logic sw_wr = 1'b0;
   logic [7:0] sw_d = 8'h00;
   logic [4:0] status;
   logic [7:0] power_control_reg;
   logic [14:0] pc_out;
   logic pc_load;
   logic push;
   logic core_rst;
   int errors = 0;
   int checks = 0;
   always #2.5 core_clk = ~core_clk;
   rcr_recorder uut (.core_clk_i(core_clk), .rst_n_i(rst_n), .por_i(ev[0]), .bor_i(ev[1]),
      .pin_i(ev[2]), .asleep_i(asleep), .wdt_i(ev[3]), .soft_i(ev[4]), .ovf_i(ev[5]),
      .unf_i(ev[6]), .stk_en_i(stk_en), .irq_i(ev[7]), .gie_i(global_irq_enable), .pc_i(pc_in),
      .sw_wr_i(sw_wr), .sw_data_i(sw_d), .status_o(status), .power_control_reg_o(power_control_reg), .pc_o(pc_out),
      .pc_load_o(pc_load), .push_o(push), .core_rst_o(core_rst));
   // ==========================================
   // access tasks
   task automatic cmp(input logic [30:0] got, input logic [30:0] exp);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask
   // full compare: status, power_control_reg, pc, {load, core reset, push}
   task automatic look(input logic [4:0] s, input logic [7:0] p, input logic [14:0] c,
         input logic [2:0] f);
      cmp({status, power_control_reg, pc_out, pc_load, core_rst, push}, {s, p, c, f});
   endtask
   // power_control_reg and pulses only, pc left out
   task automatic quiet(input logic [7:0] p);
      cmp({23'h0, power_control_reg}, {23'h0, p});
      cmp({28'h0, pc_load, core_rst, push}, 31'h0);
   endtask
   task automatic fire(input logic [7:0] e, input logic sl);
      @(posedge core_clk);
      ev <= e;
      asleep <= sl;
      @(posedge core_clk);
      ev <= 8'h00;
      #1;
   endtask
   task automatic swr(input logic [7:0] d);
      @(posedge core_clk);
      sw_wr <= 1'b1;
      sw_d <= d;
      @(posedge core_clk);
      sw_wr <= 1'b0;
      #1;
      cmp({23'h0, power_control_reg}, {23'h0, d & 8'hDF});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================
   // test sequence
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      look(5'h18, 8'h1C, 15'h0000, 3'b000);
      swr(8'hFF);
      fire(E_WDT, 1'b0);
      look(5'h08, 8'hCF, 15'h0000, 3'b110);
      fire(E_PIN, 1'b0);
      look(5'h08, 8'hC7, 15'h0000, 3'b110);
      fire(E_SOFT, 1'b0);
      look(5'h08, 8'hC3, 15'h0000, 3'b110);
      swr(8'h00);
      fire(E_OVF, 1'b0);
      quiet(8'h00);
      stk_en <= 1'b1;
      fire(E_OVF, 1'b0);
      look(5'h08, 8'h80, 15'h0000, 3'b110);
      fire(E_UNF, 1'b0);
      look(5'h08, 8'hC0, 15'h0000, 3'b110);
      swr(8'h08);
      fire(E_PIN, 1'b1);
      look(5'h10, 8'h00, 15'h0000, 3'b110);
      pc_in <= 15'h0123;
      fire(E_WDT, 1'b1);
      look(5'h00, 8'h00, 15'h0124, 3'b100);
      pc_in <= 15'h0300;
      fire(E_IRQ, 1'b1);
      look(5'h10, 8'h00, 15'h0301, 3'b100);
      @(posedge core_clk);
      #1;
      quiet(8'h00);
      global_irq_enable <= 1'b1;
      pc_in <= 15'h0200;
      fire(E_IRQ, 1'b1);
      look(5'h10, 8'h00, 15'h0201, 3'b100);
      @(posedge core_clk);
      #1;
      look(5'h10, 8'h00, 15'h0004, 3'b101);
      fire(E_SOFT, 1'b1);
      quiet(8'h00);
      swr(8'h93);
      fire(E_BOR, 1'b0);
      look(5'h18, 8'h1E, 15'h0000, 3'b110);
      swr(8'hCB);
      fire(E_POR, 1'b0);
      look(5'h18, 8'h1C, 15'h0000, 3'b110);
      swr(8'hA0);
      repeat (20) @(posedge core_clk);
      #1;
      quiet(8'h80);
      tally_and_finish();
   end
   // ==========================================
   // watchdog against a hang
   initial begin
      repeat (2000) @(posedge core_clk);
      errors++;
      tally_and_finish();
   end
endmodule
